// *** verilog/lar_ctrl_regs.sv ***
`timescale 1ns/1ps
// Overview of operation
// [RULE_01] Offset-cancel-disable bit 1 of register 0 turns off offset cancellation.
// [RULE_02] Register 1 holds the eight-bit input threshold adjust code.
// [RULE_03] Threshold adjust circuitry is enabled only when register 1 is nonzero.
// [RULE_04] Two-bit range field in register 2 scales the threshold adjustment.
// [RULE_05] Register 7 settings act only while its apply bit 7 is one.
// [RULE_06] Bit 0 of register 7 adds extra input-stage bias current.
// [RULE_07] Two-bit equalisation field in register 7; code 00 gives input equalisation.
// [RULE_08] Master should write 0x81, or 0x85 for small input swings.
// [RULE_09] Three-bit output swing code in register 3 resets to 010.
// [RULE_10] Four-bit de-emphasis code in register 2 in one decibel steps.
// [RULE_11] Bit 4 of register 0 inverts the output data polarity.
// [RULE_12] Masking time grows by 32 microseconds per count.
// [RULE_13] Largest masking setting reaches at least 2000 microseconds.
// [RULE_14] Loss-of-signal range select zero picks the low threshold range.
// [RULE_15] Loss-of-signal range select one picks the high threshold range.
// [RULE_16] Loss-of-signal range select sits at bit 2 of register 0.
// [RULE_17] Registers 13 and 12 hold rise and fall mask enable and count.
// [RULE_18] Two-wire slave at 1000100, register index then one data byte.
// [RULE_19] Registers read back as written; undocumented defaults reset to zero.
module lar_ctrl_regs (
    // Clock and reset.
    input  wire logic       clock,
    input  wire logic       rstn,
    // Two-wire serial pins.
    input  wire logic       scl_pin,
    input  wire logic       sda_pin,
    output      logic       sda_drive,
    output      logic       sda_oe,
    // Receive path settings.
    output      logic       offset_cancel_disable,
    output      logic [7:0] threshold_adjust_code,
    output      logic       threshold_adjust_enable,
    output      logic [1:0] threshold_range_select,
    output      logic       bias_boost,
    output      logic [1:0] rx_equalization_option,
    // Output stage settings.
    output      logic [2:0] output_swing_code,
    output      logic [3:0] deemphasis_code,
    output      logic       output_invert,
    // Loss-of-signal settings.
    output      logic       los_range_select,
    output      logic       los_rise_mask_enable,
    output      logic [6:0] los_rise_mask_count,
    output      logic [11:0] los_rise_mask_time_us,
    output      logic       los_fall_mask_enable,
    output      logic [6:0] los_fall_mask_count,
    output      logic [11:0] los_fall_mask_time_us
);

    ////////////////////////////////////////////////////////////////////////////////
    // Pin conditioning and bus events.

    logic [1:0]          pins_q;
    logic                scl_f;
    logic                sda_f;
    logic                scl_prev_q;
    logic                sda_prev_q;
    logic                scl_rise;
    logic                scl_fall;
    logic                bus_start;
    logic                bus_stop;

    lar_pin_sync #(
        .WIDTH      (2),
        .IDLE_LEVEL (2'h3)
    ) u_pin_sync (
        .clock   (clock),
        .rstn    (rstn),
        .pin_raw ({scl_pin, sda_pin}),
        .pin_q   (pins_q)
    );

    assign scl_f = pins_q[1];
    assign sda_f = pins_q[0];

    always_ff @(posedge clock) begin
        if (!rstn) begin
            scl_prev_q <= 1'b1;
            sda_prev_q <= 1'b1;
        end else begin
            scl_prev_q <= scl_f;
            sda_prev_q <= sda_f;
        end
    end

    assign scl_rise  = !scl_prev_q && scl_f;
    assign scl_fall  = scl_prev_q && !scl_f;
    assign bus_start = scl_prev_q && scl_f && sda_prev_q && !sda_f;
    assign bus_stop  = scl_prev_q && scl_f && !sda_prev_q && sda_f;

    ////////////////////////////////////////////////////////////////////////////////
    // Register map helpers.

    function automatic logic reg_mapped(input logic [7:0] idx);
        case (idx)
            lar_pkg::IDX_PATH_CTRL, lar_pkg::IDX_THR_ADJ, lar_pkg::IDX_DEEMPH_RNG,
            lar_pkg::IDX_OUT_SWING, lar_pkg::IDX_RX_OPT, lar_pkg::IDX_LOS_FALL,
            lar_pkg::IDX_LOS_RISE: reg_mapped = 1'b1;
            default: reg_mapped = 1'b0;
        endcase
    endfunction : reg_mapped

    ////////////////////////////////////////////////////////////////////////////////
    // Serial slave state machine.

    lar_pkg::lar_state_t state_q;
    logic [3:0]          bit_cnt_q;
    logic [7:0]          shift_q;
    logic [7:0]          tx_q;
    logic [7:0]          reg_idx_q;
    logic                byte_done;
    logic                wr_stb;
    logic [7:0]          rd_data;

    logic [7:0]          path_control_q;
    logic [7:0]          threshold_adjust_q;
    logic [7:0]          deemphasis_and_range_q;
    logic [7:0]          output_swing_q;
    logic [7:0]          receiver_optimize_q;
    logic [7:0]          los_fall_mask_q;
    logic [7:0]          los_rise_mask_q;

    assign byte_done = (bit_cnt_q == lar_pkg::BITS_PER_BYTE);
    assign wr_stb    = scl_fall && byte_done && (state_q == lar_pkg::ST_WR_DATA);

    // Bits are taken on the rising clock edge and the line is changed on the falling
    // edge, so data never moves while the serial clock is high.
    always_ff @(posedge clock) begin
        if (!rstn) begin
            bit_cnt_q <= 4'h0;
            shift_q   <= 8'h00;
        end else if (bus_start || bus_stop) begin
            bit_cnt_q <= 4'h0;
        end else if (scl_rise) begin
            // The acknowledge pulse is not a data bit: it only rearms the counter, so the
            // direction bit and the received byte survive in the shift register.
            if (byte_done) begin
                bit_cnt_q <= 4'h0;
            end else begin
                shift_q   <= {shift_q[6:0], sda_f};
                bit_cnt_q <= bit_cnt_q + 4'h1;
            end
        end
    end

    // A repeated start keeps the register index, so a read addresses what the
    // preceding write phase selected. Only one data byte is served per transfer.
    always_ff @(posedge clock) begin
        if (!rstn) begin
            state_q   <= lar_pkg::ST_IDLE;
            reg_idx_q <= 8'h00;
            tx_q      <= 8'hFF;
        end else if (bus_start) begin
            state_q <= lar_pkg::ST_DEV_ADDR; // [RULE_18]
        end else if (bus_stop) begin
            state_q <= lar_pkg::ST_IDLE;
        end else if (scl_fall) begin
            case (state_q)
                lar_pkg::ST_DEV_ADDR: begin
                    if (byte_done) begin
                        if (shift_q[7:1] == lar_pkg::SLAVE_ADDR) begin
                            state_q <= lar_pkg::ST_ACK_DEV; // [RULE_18]
                        end else begin
                            state_q <= lar_pkg::ST_IGNORE;
                        end
                    end
                end
                lar_pkg::ST_ACK_DEV: begin
                    if (shift_q[0]) begin
                        state_q <= lar_pkg::ST_RD_DATA;
                        tx_q    <= rd_data;
                    end else begin
                        state_q <= lar_pkg::ST_REG_ADDR;
                    end
                end
                lar_pkg::ST_REG_ADDR: begin
                    if (byte_done) begin
                        reg_idx_q <= shift_q; // [RULE_18]
                        state_q   <= lar_pkg::ST_ACK_REG;
                    end
                end
                lar_pkg::ST_ACK_REG: begin
                    state_q <= lar_pkg::ST_WR_DATA;
                end
                lar_pkg::ST_WR_DATA: begin
                    if (byte_done) begin
                        state_q <= lar_pkg::ST_ACK_DATA;
                    end
                end
                lar_pkg::ST_ACK_DATA: begin
                    state_q <= lar_pkg::ST_IGNORE; // [RULE_18]
                end
                lar_pkg::ST_RD_DATA: begin
                    if (byte_done) begin
                        state_q <= lar_pkg::ST_RD_ACK;
                    end else begin
                        tx_q <= {tx_q[6:0], 1'b1};
                    end
                end
                lar_pkg::ST_RD_ACK: begin
                    state_q <= lar_pkg::ST_IGNORE;
                end
                lar_pkg::ST_IDLE, lar_pkg::ST_IGNORE: begin
                    state_q <= state_q;
                end
                default: begin
                    state_q <= lar_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // The line is only ever pulled low; a high level is left to the pull-up.
    assign sda_drive = 1'b0;
    assign sda_oe = (state_q == lar_pkg::ST_ACK_DEV) || (state_q == lar_pkg::ST_ACK_REG) ||
                    (state_q == lar_pkg::ST_ACK_DATA) ||
                    ((state_q == lar_pkg::ST_RD_DATA) && !tx_q[7]);

    ////////////////////////////////////////////////////////////////////////////////
    // Register bank.

    always_comb begin
        rd_data = 8'h00;
        case (reg_idx_q)
            lar_pkg::IDX_PATH_CTRL:  rd_data = path_control_q; // [RULE_19]
            lar_pkg::IDX_THR_ADJ:    rd_data = threshold_adjust_q;
            lar_pkg::IDX_DEEMPH_RNG: rd_data = deemphasis_and_range_q;
            lar_pkg::IDX_OUT_SWING:  rd_data = output_swing_q;
            lar_pkg::IDX_RX_OPT:     rd_data = receiver_optimize_q;
            lar_pkg::IDX_LOS_FALL:   rd_data = los_fall_mask_q;
            lar_pkg::IDX_LOS_RISE:   rd_data = los_rise_mask_q;
            default:                 rd_data = 8'h00;
        endcase
    end

    // Writes to unmapped indices are acknowledged but dropped.
    always_ff @(posedge clock) begin
        if (!rstn) begin
            path_control_q         <= lar_pkg::RST_ZERO; // [RULE_19]
            threshold_adjust_q     <= lar_pkg::RST_ZERO;
            deemphasis_and_range_q <= lar_pkg::RST_ZERO;
            output_swing_q         <= lar_pkg::RST_OUT_SWING; // [RULE_09]
            receiver_optimize_q    <= lar_pkg::RST_ZERO;
            los_fall_mask_q        <= lar_pkg::RST_ZERO;
            los_rise_mask_q        <= lar_pkg::RST_ZERO;
        end else if (wr_stb && reg_mapped(reg_idx_q)) begin
            case (reg_idx_q)
                lar_pkg::IDX_PATH_CTRL:  path_control_q         <= shift_q;
                lar_pkg::IDX_THR_ADJ:    threshold_adjust_q     <= shift_q; // [RULE_02]
                lar_pkg::IDX_DEEMPH_RNG: deemphasis_and_range_q <= shift_q;
                lar_pkg::IDX_OUT_SWING:  output_swing_q         <= shift_q;
                lar_pkg::IDX_RX_OPT:     receiver_optimize_q    <= shift_q; // [RULE_08]
                lar_pkg::IDX_LOS_FALL:   los_fall_mask_q        <= shift_q; // [RULE_17]
                lar_pkg::IDX_LOS_RISE:   los_rise_mask_q        <= shift_q; // [RULE_17]
                default:                 path_control_q         <= path_control_q;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Settings presented to the analog path.

    logic rx_apply;

    assign rx_apply = receiver_optimize_q[lar_pkg::POS_RX_APPLY];

    always_ff @(posedge clock) begin
        if (!rstn) begin
            offset_cancel_disable   <= 1'b0;
            threshold_adjust_code   <= 8'h00;
            threshold_adjust_enable <= 1'b0;
            threshold_range_select  <= 2'h0;
            bias_boost              <= 1'b0;
            rx_equalization_option  <= 2'h0;
            output_swing_code       <= 3'h2;
            deemphasis_code         <= 4'h0;
            output_invert           <= 1'b0;
            los_range_select        <= 1'b0;
            los_rise_mask_enable    <= 1'b0;
            los_rise_mask_count     <= 7'h00;
            los_rise_mask_time_us   <= 12'h000;
            los_fall_mask_enable    <= 1'b0;
            los_fall_mask_count     <= 7'h00;
            los_fall_mask_time_us   <= 12'h000;
        end else begin
            offset_cancel_disable   <= path_control_q[lar_pkg::POS_OFFSET_CANCEL_DIS]; // [RULE_01]
            threshold_adjust_code   <= threshold_adjust_q; // [RULE_02]
            threshold_adjust_enable <= (threshold_adjust_q != 8'h00); // [RULE_03]
            threshold_range_select  <= // [RULE_04]
                                       deemphasis_and_range_q[lar_pkg::POS_THR_RANGE_LO +: 2];
            // Without the apply bit the receiver falls back to its built-in defaults.
            bias_boost              <= rx_apply && // [RULE_05] [RULE_06]
                                       receiver_optimize_q[lar_pkg::POS_BIAS_BOOST];
            rx_equalization_option  <= rx_apply ? receiver_optimize_q[lar_pkg::POS_RX_EQ_LO +: 2]
                                                : 2'h0; // [RULE_05] [RULE_07]
            output_swing_code       <= output_swing_q[2:0]; // [RULE_09]
            deemphasis_code         <= // [RULE_10]
                                       deemphasis_and_range_q[lar_pkg::POS_DEEMPH_LO +: 4];
            output_invert           <= path_control_q[lar_pkg::POS_OUTPUT_INVERT]; // [RULE_11]
            los_range_select        <= // [RULE_14] [RULE_15] [RULE_16]
                                       path_control_q[lar_pkg::POS_LOS_RANGE];
            los_rise_mask_enable    <= los_rise_mask_q[lar_pkg::POS_MASK_ENABLE]; // [RULE_17]
            los_rise_mask_count     <= los_rise_mask_q[6:0];
            los_rise_mask_time_us   <= {los_rise_mask_q[6:0], 5'h00}; // [RULE_12] [RULE_13]
            los_fall_mask_enable    <= los_fall_mask_q[lar_pkg::POS_MASK_ENABLE]; // [RULE_17]
            los_fall_mask_count     <= los_fall_mask_q[6:0];
            los_fall_mask_time_us   <= {los_fall_mask_q[6:0], 5'h00}; // [RULE_12] [RULE_13]
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Assertions.

    a_offset_cancel_disable_follow: assert property (@(posedge clock) disable iff (!rstn) // [RULE_01]
        wr_stb && (reg_idx_q == lar_pkg::IDX_PATH_CTRL)
        |-> ##2 (offset_cancel_disable == $past(shift_q[1], 2)))
        else $error("offset cancel disable did not follow register write");

    a_threshold_adjust_code_enable: assert property (@(posedge clock) disable iff (!rstn) // [RULE_03]
        threshold_adjust_enable == (threshold_adjust_code != 8'h00))
        else $error("threshold adjust enable disagrees with code");

    a_rx_apply_gate: assert property (@(posedge clock) disable iff (!rstn) // [RULE_05]
        !rx_apply |=> (!bias_boost && (rx_equalization_option == 2'h0)))
        else $error("receiver settings active without apply bit");

    a_swing_default: assert property (@(posedge clock) // [RULE_09]
        !rstn |=> (output_swing_q == 8'h02))
        else $error("output swing register not at default after reset");

    a_mask_step: assert property (@(posedge clock) disable iff (!rstn) // [RULE_12]
        los_rise_mask_time_us == 12'(los_rise_mask_count) * 12'h020)
        else $error("rise masking time not 32 us per count");

    a_mask_reach: assert property (@(posedge clock) disable iff (!rstn) // [RULE_13]
        (los_fall_mask_count == 7'h7F) |-> (los_fall_mask_time_us >= 12'd2000))
        else $error("largest masking time below 2000 us");

    a_invert_follow: assert property (@(posedge clock) disable iff (!rstn) // [RULE_11]
        $changed(path_control_q[4]) |=> (output_invert == $past(path_control_q[4])))
        else $error("output invert did not follow register");

    a_los_range: assert property (@(posedge clock) disable iff (!rstn) // [RULE_16]
        ##1 (los_range_select == $past(path_control_q[2])))
        else $error("loss of signal range not taken from bit 2");

    a_addr_ack: assert property (@(posedge clock) disable iff (!rstn) // [RULE_18]
        (state_q == lar_pkg::ST_DEV_ADDR) && scl_fall && byte_done && (shift_q[7:1] != 7'h44)
        |=> !sda_oe [*4])
        else $error("foreign slave address was acknowledged");

    a_read_back: assert property (@(posedge clock) disable iff (!rstn) // [RULE_19]
        wr_stb && (reg_idx_q == lar_pkg::IDX_THR_ADJ) |=> (rd_data == $past(shift_q)))
        else $error("register did not read back written value");

    c_write_done: cover property (@(posedge clock) disable iff (!rstn)
        wr_stb && (reg_idx_q == lar_pkg::IDX_RX_OPT));

    c_read_done: cover property (@(posedge clock) disable iff (!rstn)
        (state_q == lar_pkg::ST_RD_ACK) && scl_fall);

    c_foreign_addr: cover property (@(posedge clock) disable iff (!rstn)
        (state_q == lar_pkg::ST_DEV_ADDR) ##1 (state_q == lar_pkg::ST_IGNORE));

endmodule : lar_ctrl_regs

// *** verilog/lar_pkg.sv ***
package lar_pkg;

    // Serial slave identity and framing.
    localparam logic [6:0] SLAVE_ADDR     = 7'h44;
    localparam logic [3:0] BITS_PER_BYTE  = 4'h8;

    // Register indices.
    localparam logic [7:0] IDX_PATH_CTRL  = 8'h00;
    localparam logic [7:0] IDX_THR_ADJ    = 8'h01;
    localparam logic [7:0] IDX_DEEMPH_RNG = 8'h02;
    localparam logic [7:0] IDX_OUT_SWING  = 8'h03;
    localparam logic [7:0] IDX_RX_OPT     = 8'h07;
    localparam logic [7:0] IDX_LOS_FALL   = 8'h0C;
    localparam logic [7:0] IDX_LOS_RISE   = 8'h0D;

    // Field positions in the path control register.
    localparam int POS_OFFSET_CANCEL_DIS  = 1;
    localparam int POS_LOS_RANGE          = 2;
    localparam int POS_OUTPUT_INVERT      = 4;

    // Field positions in the de-emphasis and range register.
    localparam int POS_DEEMPH_LO          = 0;
    localparam int POS_THR_RANGE_LO       = 4;

    // Field positions in the receiver optimisation register.
    localparam int POS_BIAS_BOOST         = 0;
    localparam int POS_RX_EQ_LO           = 1;
    localparam int POS_RX_APPLY           = 7;

    // Field positions in the two masking registers.
    localparam int POS_MASK_ENABLE        = 7;

    // Reset values.
    localparam logic [7:0] RST_ZERO       = 8'h00;
    localparam logic [7:0] RST_OUT_SWING  = 8'h02;

    // Masking time step in microseconds and the shift that multiplies by it.
    localparam int MASK_STEP_US           = 32;
    localparam int MASK_STEP_SHIFT        = $clog2(MASK_STEP_US);
    localparam int MASK_TIME_MIN_MAX_US   = 2000;

    typedef enum logic [3:0] {
        ST_IDLE,
        ST_DEV_ADDR,
        ST_ACK_DEV,
        ST_REG_ADDR,
        ST_ACK_REG,
        ST_WR_DATA,
        ST_ACK_DATA,
        ST_RD_DATA,
        ST_RD_ACK,
        ST_IGNORE
    } lar_state_t;

endpackage : lar_pkg

// *** verilog/lar_pin_sync.sv ***
`timescale 1ns/1ps
module lar_pin_sync #(
    parameter int          WIDTH      = 2,
    parameter logic [1:0]  IDLE_LEVEL = 2'h3
) (
    // Clock and reset.
    input  wire logic             clock,
    input  wire logic             rstn,
    // Raw pin levels and their filtered copies.
    input  wire logic [WIDTH-1:0] pin_raw,
    output      logic [WIDTH-1:0] pin_q
);

    logic [WIDTH-1:0] s1_q;
    logic [WIDTH-1:0] s2_q;
    logic [WIDTH-1:0] s3_q;

    // The first stage feeds only the second; the filter compares stages two and three.
    genvar g;
    generate
        for (g = 0; g < WIDTH; g++) begin : g_bit
            always_ff @(posedge clock) begin
                if (!rstn) begin
                    s1_q[g]  <= IDLE_LEVEL[g];
                    s2_q[g]  <= IDLE_LEVEL[g];
                    s3_q[g]  <= IDLE_LEVEL[g];
                    pin_q[g] <= IDLE_LEVEL[g];
                end else begin
                    s1_q[g] <= pin_raw[g];
                    s2_q[g] <= s1_q[g];
                    s3_q[g] <= s2_q[g];
                    if (s2_q[g] == s3_q[g]) begin
                        pin_q[g] <= s3_q[g];
                    end
                end
            end
        end
    endgenerate

endmodule : lar_pin_sync

// *** bench/lar_i2c_master.sv ***
`timescale 1ns/1ps
module lar_i2c_master (
    // Clock.
    input  wire logic clock,
    // Bus lines; the data line is only ever pulled low, never driven high.
    output      logic scl,
    output      logic sda_low,
    input  wire logic sda
);
    // Six clocks per third of a bit keeps each clock phase well above the input filter delay.
    localparam int H = 6;
    localparam logic [6:0] DEV = 7'h44;

    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic wt();
        repeat (H) @(posedge clock);
    endtask : wt

    task automatic bit_io(input logic b, output logic r);
        sda_low <= !b;
        wt();
        scl <= 1'b1;
        wt();
        r = sda;
        scl <= 1'b0;
        wt();
    endtask : bit_io

    task automatic xfer(input logic [7:0] tx, input logic mack, output logic [7:0] rx,
                        output logic ack);
        for (int i = 7; i >= 0; i--) bit_io(tx[i], rx[i]);
        bit_io(mack, ack);
    endtask : xfer

    task automatic start();
        sda_low <= 1'b0;
        wt();
        scl <= 1'b1;
        wt();
        sda_low <= 1'b1;
        wt();
        scl <= 1'b0;
        wt();
    endtask : start

    task automatic stop();
        sda_low <= 1'b1;
        wt();
        scl <= 1'b1;
        wt();
        sda_low <= 1'b0;
        wt();
    endtask : stop

    ////////////////////////////////////////////////////////////////////////////////
    task automatic write_reg(input logic [6:0] dev, input logic [7:0] idx, d,
                             output logic [2:0] ak);
        logic [7:0] rx;
        start();
        xfer({dev, 1'b0}, 1'b1, rx, ak[2]);
        xfer(idx, 1'b1, rx, ak[1]);
        xfer(d, 1'b1, rx, ak[0]);
        stop();
    endtask : write_reg

    task automatic read_reg(input logic [7:0] idx, output logic [7:0] d, output logic [2:0] ak);
        logic [7:0] rx;
        logic       nack;
        start();
        xfer({DEV, 1'b0}, 1'b1, rx, ak[2]);
        xfer(idx, 1'b1, rx, ak[1]);
        start();
        xfer({DEV, 1'b1}, 1'b1, rx, ak[0]);
        xfer(8'hFF, 1'b1, d, nack);
        stop();
    endtask : read_reg
endmodule : lar_i2c_master

// *** bench/testbench.sv ***
`timescale 1ns/1ps
module testbench;
    logic        clock = 1'b0;
    logic        rstn = 1'b0;
    logic        scl, sda_low, sda_drive, sda_oe;
    logic        offset_cancel_disable, threshold_adjust_enable, bias_boost, output_invert;
    logic        los_range_select, los_rise_mask_enable, los_fall_mask_enable;
    logic [1:0]  threshold_range_select, rx_equalization_option;
    logic [2:0]  output_swing_code;
    logic [3:0]  deemphasis_code;
    logic [6:0]  los_rise_mask_count, los_fall_mask_count;
    logic [7:0]  threshold_adjust_code;
    logic [11:0] los_rise_mask_time_us, los_fall_mask_time_us;
    int          error_cnt = 0;
    int          n_tests = 0;
    // The data line has a pull-up, so it reads high whenever nobody pulls it low.
    wire         sda_line = !(sda_low || (sda_oe && !sda_drive));
    wire [2:0]   path_bits = {offset_cancel_disable, los_range_select, output_invert};

    always #5 clock = ~clock;

    lar_ctrl_regs dut (.clock, .rstn, .scl_pin(scl), .sda_pin(sda_line), .sda_drive, .sda_oe,
        .offset_cancel_disable, .threshold_adjust_code, .threshold_adjust_enable,
        .threshold_range_select, .bias_boost, .rx_equalization_option, .output_swing_code,
        .deemphasis_code, .output_invert, .los_range_select, .los_rise_mask_enable,
        .los_rise_mask_count, .los_rise_mask_time_us, .los_fall_mask_enable,
        .los_fall_mask_count, .los_fall_mask_time_us);
    lar_i2c_master mst (.clock, .scl, .sda_low, .sda(sda_line));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input string nm, input logic [15:0] seen, exp);
        n_tests++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    task automatic complete_run();
        $display("Checks %0d, mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : complete_run

    task automatic wr(input logic [7:0] idx, d);
        logic [2:0] ak;
        logic [7:0] rd;
        mst.write_reg(7'h44, idx, d, ak);
        check("write ack", 16'(ak), 16'h0000);
        mst.read_reg(idx, rd, ak);
        check("read ack", 16'(ak), 16'h0000);
        check("readback", 16'(rd), 16'(d));
    endtask : wr

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset_and_refuse();
        logic [2:0] ak;
        logic [7:0] rd;
        check("reset swing", 16'(output_swing_code), 16'h0002);
        check("reset path", 16'({offset_cancel_disable, threshold_adjust_enable,
            bias_boost, los_rise_mask_time_us}), 16'h0000);
        mst.read_reg(8'h03, rd, ak);
        check("reset reg3", 16'(rd), 16'h0002);
        mst.write_reg(7'h45, 8'h03, 8'h07, ak);
        check("foreign ack", 16'(ak), 16'h0007);
        check("foreign swing", 16'(output_swing_code), 16'h0002);
        mst.write_reg(7'h44, 8'h05, 8'h5A, ak);
        mst.read_reg(8'h05, rd, ak);
        check("unmapped", 16'({ak, rd}), 16'h0000);
        wr(8'h03, 8'h07);
        check("swing", 16'(output_swing_code), 16'h0007);
    endtask : t_reset_and_refuse

    task automatic t_path();
        wr(8'h00, 8'h16);
        check("path set", 16'(path_bits), 16'h0007);
        wr(8'h00, 8'h02);
        check("path low", 16'(path_bits), 16'h0004);
    endtask : t_path

    task automatic t_thr_and_opt();
        logic [7:0] tv [4] = '{8'h00, 8'h01, 8'hA5, 8'hFF};
        logic [7:0] rv [4] = '{8'h05, 8'h81, 8'h85, 8'h87};
        foreach (tv[i]) begin
            wr(8'h01, tv[i]);
            check("thr code", 16'(threshold_adjust_code), 16'(tv[i]));
            check("thr en", 16'(threshold_adjust_enable), 16'(tv[i] != 8'h00));
        end
        foreach (rv[i]) begin
            wr(8'h07, rv[i]);
            check("bias", 16'(bias_boost), 16'(rv[i][7] & rv[i][0]));
            check("eq", 16'(rx_equalization_option),
                16'(rv[i][7] ? rv[i][2:1] : 2'h0));
        end
        wr(8'h02, 8'h38);
        check("deemph", 16'({threshold_range_select, deemphasis_code}),
            16'h0038);
        wr(8'h02, 8'h17);
        check("deemph", 16'({threshold_range_select, deemphasis_code}),
            16'h0017);
    endtask : t_thr_and_opt

    task automatic t_mask();
        wr(8'h0D, 8'hFF);
        check("rise", 16'({los_rise_mask_enable, los_rise_mask_count}), 16'h00FF);
        check("rise time", 16'(los_rise_mask_time_us), 16'h0FE0);
        check("max time", 16'(los_rise_mask_time_us >= 12'd2000), 16'h0001);
        wr(8'h0C, 8'h01);
        check("fall", 16'({los_fall_mask_enable, los_fall_mask_count}), 16'h0001);
        check("fall time", 16'(los_fall_mask_time_us), 16'h0020);
    endtask : t_mask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        #500000;
        error_cnt++;
        complete_run();
    end

    initial begin
        repeat (8) @(posedge clock);
        rstn <= 1'b1;
        repeat (10) @(posedge clock);
        t_reset_and_refuse();
        t_path();
        t_thr_and_opt();
        t_mask();
        complete_run();
    end
endmodule : testbench
